// ==== src/pix_defines.svh ====
// Constants for the peripheral interrupt expansion block.
// Assumes inclusion by bare name from the selector, arbiter and top files.
`ifndef PIX_DEFINES_SVH
`define PIX_DEFINES_SVH

// ----------------------------------------------------------------
// Source ranges, priorities and core vectors
// ----------------------------------------------------------------
`define PIX_L1_LO      5'd0
`define PIX_L1_HI      5'd9
`define PIX_L2_LO      5'd10
`define PIX_L2_HI      5'd23
`define PIX_PRIO_RESET 6'd1
`define PIX_PRIO_EMU   6'd2
`define PIX_PRIO_NMI   6'd3
`define PIX_PRIO_BASE  6'd4
`define PIX_VEC_RESET  16'h0000
`define PIX_VEC_EMU    16'h0026
`define PIX_VEC_NMI    16'h0024
`define PIX_VEC_LVL1   16'h0002
`define PIX_VEC_LVL2   16'h0004

// ----------------------------------------------------------------
// Peripheral vector codes, by source index (priority minus 4)
// ----------------------------------------------------------------
`define PIX_CODE_00 16'h0020
`define PIX_CODE_01 16'h0019
`define PIX_CODE_02 16'h0004
`define PIX_CODE_03 16'h0001
`define PIX_CODE_04 16'h0011
`define PIX_CODE_05 16'h0005
`define PIX_CODE_06 16'h0006
`define PIX_CODE_07 16'h0007
`define PIX_CODE_08 16'h0040
`define PIX_CODE_09 16'h0041
`define PIX_CODE_10 16'h0021
`define PIX_CODE_11 16'h0022
`define PIX_CODE_12 16'h0023
`define PIX_CODE_13 16'h0027
`define PIX_CODE_14 16'h0028
`define PIX_CODE_15 16'h0029
`define PIX_CODE_16 16'h002a
`define PIX_CODE_17 16'h0024
`define PIX_CODE_18 16'h0025
`define PIX_CODE_19 16'h0026
`define PIX_CODE_20 16'h002f
`define PIX_CODE_21 16'h0030
`define PIX_CODE_22 16'h0031
`define PIX_CODE_23 16'h0032

// ----------------------------------------------------------------
// Register offsets, event bits and reset values
// ----------------------------------------------------------------
`define PIX_OFF_PEND0  8'h00
`define PIX_OFF_PEND2  8'h04
`define PIX_OFF_ACK0   8'h08
`define PIX_OFF_ACK2   8'h0c
`define PIX_OFF_EN0    8'h10
`define PIX_OFF_EN2    8'h14
`define PIX_OFF_ISTAT  8'h18
`define PIX_OFF_IMASK  8'h1c
`define PIX_OFF_CODE   8'h20
`define PIX_OFF_CORE   8'h24
`define PIX_EV_RESET   0
`define PIX_EV_EMU     1
`define PIX_EV_NMI     2
`define PIX_EV_LVL1    3
`define PIX_EV_LVL2    4
`define PIX_EN0_RST    16'h0000
`define PIX_EN2_RST    8'h00
`define PIX_IMASK_RST  5'h00
`endif

// ==== src/pix_pkg.sv ====
// Types shared by the interrupt expansion modules.
// Assumes nothing of its surroundings.
package pix_pkg;
  typedef logic [23:0] pix_src_type;
  typedef enum logic [2:0] {
    PIX_NONE, PIX_RESET, PIX_EMU, PIX_NMI, PIX_LVL1, PIX_LVL2
  } pix_kind_type;
  typedef enum {PIX_ST_IDLE, PIX_ST_OFFER, PIX_ST_GAP} pix_state_type;
endpackage

// ==== src/pix_sel_if.sv ====
// Carrier between the top and one level selector.
// Assumes the top drives pend and the selector the rest.
`timescale 1ns/1ns
interface pix_sel_if;
  pix_pkg::pix_src_type pend;
  logic                 valid;
  logic [4:0]           index;
  logic [15:0]          code;
  modport sel  (input pend, output valid, index, code);
  modport user (input valid, index, code, output pend);
endinterface

// ==== src/pix_level_sel.sv ====
// Picks the lowest-numbered pending source within one core level.
// Assumes pend is already gated by the source enables.
`timescale 1ns/1ns
`include "pix_defines.svh"
module pix_level_sel #(
  parameter logic [4:0] LO = 5'd0,
  parameter logic [4:0] HI = 5'd23
) (
  pix_sel_if.sel s
);
  import pix_pkg::*;

  function automatic logic [15:0] code_of(input logic [4:0] i);
    case (i)
      5'd0:    code_of = `PIX_CODE_00;
      5'd1:    code_of = `PIX_CODE_01;
      5'd2:    code_of = `PIX_CODE_02;
      5'd3:    code_of = `PIX_CODE_03;
      5'd4:    code_of = `PIX_CODE_04;
      5'd5:    code_of = `PIX_CODE_05;
      5'd6:    code_of = `PIX_CODE_06;
      5'd7:    code_of = `PIX_CODE_07;
      5'd8:    code_of = `PIX_CODE_08;
      5'd9:    code_of = `PIX_CODE_09;
      5'd10:   code_of = `PIX_CODE_10;
      5'd11:   code_of = `PIX_CODE_11;
      5'd12:   code_of = `PIX_CODE_12;
      5'd13:   code_of = `PIX_CODE_13;
      5'd14:   code_of = `PIX_CODE_14;
      5'd15:   code_of = `PIX_CODE_15;
      5'd16:   code_of = `PIX_CODE_16;
      5'd17:   code_of = `PIX_CODE_17;
      5'd18:   code_of = `PIX_CODE_18;
      5'd19:   code_of = `PIX_CODE_19;
      5'd20:   code_of = `PIX_CODE_20;
      5'd21:   code_of = `PIX_CODE_21;
      5'd22:   code_of = `PIX_CODE_22;
      5'd23:   code_of = `PIX_CODE_23;
      default: code_of = 16'h0000;
    endcase
  endfunction

  // Scan downward so the lowest index wins
  always_comb begin
    s.valid = 1'b0;
    s.index = 5'd0;
    for (int i = 23; i >= 0; i--) begin
      if (5'(i) >= LO && 5'(i) <= HI && s.pend[i]) begin
        s.valid = 1'b1;
        s.index = 5'(i);
      end
    end
    s.code = code_of(s.index);
  end
endmodule

// ==== src/pix_core_arb.sv ====
// Ranks the core-level requests by overall priority.
// Assumes all inputs settle within the same clock cycle.
`timescale 1ns/1ns
`include "pix_defines.svh"
module pix_core_arb (
  input  wire logic         rst_pend,
  input  wire logic         emu_pend,
  input  wire logic         nmi_pend,
  pix_sel_if.user           l1,
  pix_sel_if.user           l2,
  output pix_pkg::pix_kind_type kind,
  output logic [15:0]       vector,
  output logic [5:0]        prio
);
  import pix_pkg::*;

  always_comb begin
    kind   = PIX_NONE;
    vector = `PIX_VEC_RESET;
    prio   = 6'd0;
    if (rst_pend) begin
      kind   = PIX_RESET;
      vector = `PIX_VEC_RESET;
      prio   = `PIX_PRIO_RESET;
    end else if (emu_pend) begin
      kind   = PIX_EMU;
      vector = `PIX_VEC_EMU;
      prio   = `PIX_PRIO_EMU;
    end else if (nmi_pend) begin
      kind   = PIX_NMI;
      vector = `PIX_VEC_NMI;
      prio   = `PIX_PRIO_NMI;
    end else if (l1.valid) begin
      kind   = PIX_LVL1;
      vector = `PIX_VEC_LVL1;
      prio   = `PIX_PRIO_BASE + {1'b0, l1.index};
    end else if (l2.valid) begin
      kind   = PIX_LVL2;
      vector = `PIX_VEC_LVL2;
      prio   = `PIX_PRIO_BASE + {1'b0, l2.index};
    end
  end
endmodule

// ==== src/pix_top.sv ====
// Peripheral interrupt expansion: latches peripheral requests, ranks
// them onto core levels one and two and hands vectors to the core.
// Assumes request inputs are synchronous one-cycle or level pulses
// and that the core pulses core_ack once per offered request.
`timescale 1ns/1ns
`include "pix_defines.svh"
module pix_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic        soft_nmi_req,
  input  wire logic        emu_trap_req,
  input  wire logic        drive_protect_a,
  input  wire logic        drive_protect_b,
  input  wire logic        converter_req,
  input  wire logic        ext_pin_req_one,
  input  wire logic        ext_pin_req_two,
  input  wire logic        serial_periph_req,
  input  wire logic        serial_rx_req,
  input  wire logic        serial_tx_req,
  input  wire logic        can_mailbox_req,
  input  wire logic        can_error_req,
  input  wire logic        compare_one_req,
  input  wire logic        compare_two_req,
  input  wire logic        compare_three_req,
  input  wire logic        timer_one_period_req,
  input  wire logic        timer_one_compare_req,
  input  wire logic        timer_one_underflow_req,
  input  wire logic        timer_one_overflow_req,
  input  wire logic        compare_four_req,
  input  wire logic        compare_five_req,
  input  wire logic        compare_six_req,
  input  wire logic        timer_three_period_req,
  input  wire logic        timer_three_compare_req,
  input  wire logic        timer_three_underflow_req,
  input  wire logic        timer_three_overflow_req,
  input  wire logic        core_ack,
  output logic             core_req,
  output logic [15:0]      core_vector,
  output logic [5:0]       core_priority,
  output logic             core_level_one,
  output logic             core_level_two,
  output logic [15:0]      source_vector_code,
  output logic             irq
);
  import pix_pkg::*;

  // ----------------------------------------------------------------
  // Register layout mapping
  // ----------------------------------------------------------------
  // Internally sources sit in priority order; these map to and from
  // the request/acknowledge register bit layout.
  function automatic logic [15:0] to_reg0(input pix_src_type v);
    to_reg0 = {v[16:10], v[9:2], v[0]};
  endfunction

  function automatic logic [7:0] to_reg2(input pix_src_type v);
    to_reg2 = {v[23:17], v[1]};
  endfunction

  function automatic pix_src_type from_regs(input logic [15:0] r0,
                                            input logic [7:0]  r2);
    from_regs = {r2[7:1], r0[15:9], r0[8:1], r2[0], r0[0]};
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `PIX_OFF_PEND0, `PIX_OFF_PEND2, `PIX_OFF_ACK0, `PIX_OFF_ACK2,
      `PIX_OFF_EN0, `PIX_OFF_EN2, `PIX_OFF_ISTAT, `PIX_OFF_IMASK,
      `PIX_OFF_CODE, `PIX_OFF_CORE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pix_src_type   req_vec;
  pix_src_type   pend_r;
  pix_src_type   pend_nxt;
  pix_src_type   sw_clr;
  pix_src_type   core_clr;
  pix_src_type   en_vec;
  logic [15:0]   en0_r;
  logic [7:0]    en2_r;
  logic          rst_pend_r;
  logic          emu_pend_r;
  logic          nmi_pend_r;
  logic [4:0]    stat_r;
  logic [4:0]    stat_nxt;
  logic [4:0]    imask_r;
  logic [4:0]    ev_set;
  pix_state_type state_r;
  pix_kind_type  kind_r;
  pix_kind_type  arb_kind;
  logic [15:0]   arb_vector;
  logic [5:0]    arb_prio;
  logic [4:0]    idx_r;
  logic          ack_hit;
  logic          wr_en;
  logic [31:0]   rd_mux;

  pix_sel_if l1_if ();
  pix_sel_if l2_if ();

  // ----------------------------------------------------------------
  // Request collection
  // ----------------------------------------------------------------
  assign req_vec = {
    timer_three_overflow_req, timer_three_underflow_req,
    timer_three_compare_req,  timer_three_period_req,
    compare_six_req, compare_five_req, compare_four_req,
    timer_one_overflow_req,   timer_one_underflow_req,
    timer_one_compare_req,    timer_one_period_req,
    compare_three_req, compare_two_req, compare_one_req,
    can_error_req,
    can_mailbox_req,
    serial_tx_req,
    serial_rx_req,
    serial_periph_req,
    ext_pin_req_two, ext_pin_req_one,
    converter_req, drive_protect_b, drive_protect_a
  };

  // Pending bits are kept even while disabled; the enables only gate
  // which sources take part in the ranking.
  assign en_vec     = from_regs(en0_r, en2_r);
  assign l1_if.pend = pend_r & en_vec;
  assign l2_if.pend = pend_r & en_vec;

  pix_level_sel #(.LO(`PIX_L1_LO), .HI(`PIX_L1_HI)) u_sel_l1 (
    .s (l1_if)
  );

  pix_level_sel #(.LO(`PIX_L2_LO), .HI(`PIX_L2_HI)) u_sel_l2 (
    .s (l2_if)
  );

  pix_core_arb u_arb (
    .rst_pend (rst_pend_r),
    .emu_pend (emu_pend_r),
    .nmi_pend (nmi_pend_r),
    .l1       (l1_if),
    .l2       (l2_if),
    .kind     (arb_kind),
    .vector   (arb_vector),
    .prio     (arb_prio)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // pready comes from a flop, so every access has one wait-free
  // access cycle and read data is captured in the setup cycle.
  assign wr_en = psel & penable & pwrite & pready;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `PIX_OFF_PEND0: rd_mux = {16'h0000, to_reg0(pend_r)};
      `PIX_OFF_PEND2: rd_mux = {24'h00_0000, to_reg2(pend_r)};
      `PIX_OFF_EN0:   rd_mux = {16'h0000, en0_r};
      `PIX_OFF_EN2:   rd_mux = {24'h00_0000, en2_r};
      `PIX_OFF_ISTAT: rd_mux = {27'h000_0000, stat_r};
      `PIX_OFF_IMASK: rd_mux = {27'h000_0000, imask_r};
      `PIX_OFF_CODE:  rd_mux = {16'h0000, source_vector_code};
      `PIX_OFF_CORE:  rd_mux = {7'h00, core_req, 2'h0, core_priority,
                                core_vector};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en0_r   <= `PIX_EN0_RST;
      en2_r   <= `PIX_EN2_RST;
      imask_r <= `PIX_IMASK_RST;
    end else if (wr_en) begin
      if (paddr == `PIX_OFF_EN0) begin
        en0_r <= pwdata[15:0];
      end
      if (paddr == `PIX_OFF_EN2) begin
        en2_r <= pwdata[7:0];
      end
      if (paddr == `PIX_OFF_IMASK) begin
        imask_r <= pwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending request bits
  // ----------------------------------------------------------------
  always_comb begin
    sw_clr = '0;
    if (wr_en && paddr == `PIX_OFF_ACK0) begin
      sw_clr = from_regs(pwdata[15:0], 8'h00);
    end
    if (wr_en && paddr == `PIX_OFF_ACK2) begin
      sw_clr = from_regs(16'h0000, pwdata[7:0]);
    end
  end

  assign ack_hit  = (state_r == PIX_ST_OFFER) && core_ack;
  assign core_clr = (ack_hit && (kind_r == PIX_LVL1 ||
                                 kind_r == PIX_LVL2))
                    ? (pix_src_type'(1) << idx_r) : '0;

  // A request in the same cycle as its clear is kept
  assign pend_nxt = (pend_r & ~(sw_clr | core_clr)) | req_vec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // Nonmaskable requests bypass the enables entirely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pend_r <= 1'b0;
      emu_pend_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      rst_pend_r <= (rst_pend_r & ~(ack_hit && kind_r == PIX_RESET))
                    | ~reset_pin_n | watchdog_timeout;
      emu_pend_r <= (emu_pend_r & ~(ack_hit && kind_r == PIX_EMU))
                    | emu_trap_req;
      nmi_pend_r <= (nmi_pend_r & ~(ack_hit && kind_r == PIX_NMI))
                    | soft_nmi_req;
    end
  end

  // ----------------------------------------------------------------
  // Core hand-off
  // ----------------------------------------------------------------
  // The offer is frozen until the core acknowledges it; the gap
  // cycle lets the cleared bit reach the selectors before the next
  // offer, so one source is never offered twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= PIX_ST_IDLE;
      kind_r        <= PIX_NONE;
      idx_r         <= 5'd0;
      core_req      <= 1'b0;
      core_vector   <= 16'h0000;
      core_priority <= 6'd0;
    end else begin
      case (state_r)
        PIX_ST_IDLE: begin
          if (arb_kind != PIX_NONE) begin
            state_r       <= PIX_ST_OFFER;
            kind_r        <= arb_kind;
            idx_r         <= (arb_kind == PIX_LVL2) ? l2_if.index
                                                    : l1_if.index;
            core_req      <= 1'b1;
            core_vector   <= arb_vector;
            core_priority <= arb_prio;
          end
        end
        PIX_ST_OFFER: begin
          if (core_ack) begin
            state_r  <= PIX_ST_GAP;
            core_req <= 1'b0;
          end
        end
        PIX_ST_GAP: begin
          state_r <= PIX_ST_IDLE;
          kind_r  <= PIX_NONE;
        end
        default: begin
          state_r  <= PIX_ST_IDLE;
          core_req <= 1'b0;
        end
      endcase
    end
  end

  // Code of the source taken, kept for the handler to read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_vector_code <= 16'h0000;
    end else if (ack_hit && kind_r == PIX_LVL1) begin
      source_vector_code <= l1_code_at(idx_r);
    end else if (ack_hit && kind_r == PIX_LVL2) begin
      source_vector_code <= l1_code_at(idx_r);
    end
  end

  // Level lines follow the enabled pending bits of each group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_level_one <= 1'b0;
      core_level_two <= 1'b0;
    end else begin
      core_level_one <= l1_if.valid;
      core_level_two <= l2_if.valid;
    end
  end

  // Vector code of a given index, same table as the selectors use
  function automatic logic [15:0] l1_code_at(input logic [4:0] i);
    logic [15:0] t [24];
    t = '{`PIX_CODE_00, `PIX_CODE_01, `PIX_CODE_02, `PIX_CODE_03,
          `PIX_CODE_04, `PIX_CODE_05, `PIX_CODE_06, `PIX_CODE_07,
          `PIX_CODE_08, `PIX_CODE_09, `PIX_CODE_10, `PIX_CODE_11,
          `PIX_CODE_12, `PIX_CODE_13, `PIX_CODE_14, `PIX_CODE_15,
          `PIX_CODE_16, `PIX_CODE_17, `PIX_CODE_18, `PIX_CODE_19,
          `PIX_CODE_20, `PIX_CODE_21, `PIX_CODE_22, `PIX_CODE_23};
    l1_code_at = (i < 5'd24) ? t[i] : 16'h0000;
  endfunction

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = 5'h00;
    if (ack_hit) begin
      case (kind_r)
        PIX_RESET: ev_set[`PIX_EV_RESET] = 1'b1;
        PIX_EMU:   ev_set[`PIX_EV_EMU]   = 1'b1;
        PIX_NMI:   ev_set[`PIX_EV_NMI]   = 1'b1;
        PIX_LVL1:  ev_set[`PIX_EV_LVL1]  = 1'b1;
        PIX_LVL2:  ev_set[`PIX_EV_LVL2]  = 1'b1;
        default:   ev_set = 5'h00;
      endcase
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_comb begin
    stat_nxt = stat_r;
    if (wr_en && paddr == `PIX_OFF_ISTAT) begin
      stat_nxt = stat_r & ~pwdata[4:0];
    end
    stat_nxt = stat_nxt | ev_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 5'h00;
      irq    <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq    <= |(stat_nxt & imask_r);
    end
  end
endmodule

// ==== src/pix_top_dummy_guard.sv ====
// Holds no module; the expansion logic lives in pix_top.
// Assumes nothing of its surroundings.
`timescale 1ns/1ns

// ==== verification/pix_core_model.sv ====
// Core side: acknowledges each offer after dly idle cycles.
// Assumes one clock and an active low async reset.
`timescale 1ns/1ns
module pix_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       core_req,
  input  wire logic [1:0] dly,
  output logic            core_ack
);
  logic [1:0] cnt_r;
  // ----------------------------------------
  // Ack pulse, one cycle, only while offered
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      cnt_r    <= 2'h0;
    end else if (core_ack || !core_req) begin
      core_ack <= 1'b0;
      cnt_r    <= 2'h0;
    end else if (cnt_r == dly) begin
      core_ack <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// ==== verification/pix_top_monitor.sv ====
// Checker on the core-side ports of the expansion block.
// Assumes it is bound onto pix_top.
`timescale 1ns/1ns
module pix_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        core_ack,
  input wire logic        core_req,
  input wire logic [15:0] core_vector,
  input wire logic [5:0]  core_priority,
  input wire logic [15:0] source_vector_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Vectors by rank
  // ----------------------------------------
  a_reset_vec: assert property (
    core_req && core_priority == 6'h01 |-> core_vector == 16'h0000)
    else $error("reset vector wrong");
  a_emu_vec: assert property (
    core_req && core_priority == 6'h02 |-> core_vector == 16'h0026)
    else $error("trap vector wrong");
  a_nmi_vec: assert property (
    core_req && core_priority == 6'h03 |-> core_vector == 16'h0024)
    else $error("nmi vector wrong");
  a_lvl1_vec: assert property (
    core_req && core_priority inside {[6'h04:6'h0d]}
    |-> core_vector == 16'h0002) else $error("level one vector wrong");
  a_lvl2_vec: assert property (
    core_req && core_priority inside {[6'h0e:6'h1b]}
    |-> core_vector == 16'h0004) else $error("level two vector wrong");
  // ----------------------------------------
  // Offer life cycle
  // ----------------------------------------
  a_offer_held: assert property (
    core_req && !core_ack |=> core_req && $stable(core_vector)
    && $stable(core_priority)) else $error("offer changed before ack");
  a_ack_gap: assert property (
    core_req && core_ack |=> !core_req [*2])
    else $error("no gap after ack");
  a_mailbox_code: assert property (
    core_req && core_ack && core_priority == 6'h0c
    |=> source_vector_code == 16'h0040) else $error("mailbox code wrong");
endmodule
bind pix_top pix_top_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .core_ack(core_ack), .core_req(core_req), .core_vector(core_vector),
  .core_priority(core_priority), .source_vector_code(source_vector_code));

// ==== verification/test_peripheral_interrupt_expansion.sv ====
// Self-checking bench for the expansion block, with a core model.
// Assumes the pix_top port list and its APB register map.
`timescale 1ns/1ns
module test_peripheral_interrupt_expansion;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        reset_pin_n = 1, watchdog_timeout = 0, slv;
  logic        soft_nmi_req = 0, emu_trap_req = 0, core_ack, core_req;
  logic        pready, pslverr, core_level_one, core_level_two, irq;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] core_vector, source_vector_code;
  logic [5:0]  core_priority;
  logic [23:0] rq = 0, rr, en, hit;
  logic [1:0]  dly = 0;
  int          err_total = 0, n_compared = 0, p, n, eq[$];
  int          ps[24] = '{0,16,1,2,3,4,5,6,7,8,9,10,11,12,13,14,15,
                          17,18,19,20,21,22,23};
  logic [15:0] cd[24] = '{16'h20,16'h19,16'h4,16'h1,16'h11,16'h5,16'h6,
    16'h7,16'h40,16'h41,16'h21,16'h22,16'h23,16'h27,16'h28,16'h29,16'h2a,
    16'h24,16'h25,16'h26,16'h2f,16'h30,16'h31,16'h32};
  always #25 pclk = ~pclk;
  pix_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .soft_nmi_req(soft_nmi_req), .emu_trap_req(emu_trap_req),
    .core_ack(core_ack), .core_req(core_req), .core_vector(core_vector),
    .core_priority(core_priority), .core_level_one(core_level_one),
    .core_level_two(core_level_two),
    .source_vector_code(source_vector_code), .irq(irq),
    .drive_protect_a(rq[0]), .drive_protect_b(rq[1]),
    .converter_req(rq[2]), .ext_pin_req_one(rq[3]),
    .ext_pin_req_two(rq[4]), .serial_periph_req(rq[5]),
    .serial_rx_req(rq[6]), .serial_tx_req(rq[7]),
    .can_mailbox_req(rq[8]), .can_error_req(rq[9]),
    .compare_one_req(rq[10]), .compare_two_req(rq[11]),
    .compare_three_req(rq[12]), .timer_one_period_req(rq[13]),
    .timer_one_compare_req(rq[14]), .timer_one_underflow_req(rq[15]),
    .timer_one_overflow_req(rq[16]), .compare_four_req(rq[17]),
    .compare_five_req(rq[18]), .compare_six_req(rq[19]),
    .timer_three_period_req(rq[20]), .timer_three_compare_req(rq[21]),
    .timer_three_underflow_req(rq[22]), .timer_three_overflow_req(rq[23]));
  pix_core_model i_core (.pclk(pclk), .presetn(presetn),
    .core_req(core_req), .dly(dly), .core_ack(core_ack));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Queue built before the pulse so no offer can outrun it
  task automatic go(input logic [23:0] v, x);
    eq = {1, 2, 3};
    for (int i = 0; i < 24; i++) if (x[i]) eq.push_back(i + 4);
    rq <= v;
    // Reset from the watchdog or from the pin, picked by x[0]
    {watchdog_timeout, reset_pin_n} <= {x[0], x[0]};
    {soft_nmi_req, emu_trap_req} <= 2'b11;
    @(posedge pclk);
    rq <= 24'h0;
    {watchdog_timeout, reset_pin_n, soft_nmi_req, emu_trap_req} <= 4'b0100;
    repeat (2) @(posedge pclk);
    chk(core_level_one, |x[9:0]);
    chk(core_level_two, |x[23:10]);
    n = 0;
    while (eq.size() > 0 && n < 900) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    chk(eq.size(), 0);
  endtask
  function automatic logic [23:0] mp(input logic [23:0] v);
    mp = 24'h0;
    for (int i = 0; i < 24; i++) mp[ps[i]] = v[i];
  endfunction
  // ----------------------------------------
  // Offers checked at every ack
  // ----------------------------------------
  always @(posedge pclk) begin
    if (core_req === 1'b1 && core_ack === 1'b1) begin
      p = eq.pop_front();
      chk(core_priority, p);
      chk(core_vector, p == 1 ? 0 : p == 2 ? 'h26 : p == 3 ? 'h24 :
          p < 14 ? 2 : 4);
      if (p > 3) begin
        @(posedge pclk);
        chk(source_vector_code, cd[p-4]);
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h228c));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({core_req, irq}, 0);
    apb(0, 8'h28, 0);
    chk({31'h0, slv}, 1);
    chk(q, 0);
    for (int r = 0; r < 3; r++) begin
      rr = 24'($urandom);
      en = 24'($urandom);
      hit = rr & en;
      dly <= 2'($urandom);
      apb(1, 8'h10, 0);
      apb(1, 8'h14, 0);
      apb(1, 8'h08, 'hffff);
      apb(1, 8'h0c, 'hff);
      go(rr, 0);
      apb(0, 8'h00, 0);
      chk(q, mp(rr) & 'hffff);
      apb(0, 8'h04, 0);
      chk(q, mp(rr) >> 16);
      apb(1, 8'h08, 'hffff);
      apb(1, 8'h0c, 'hff);
      apb(0, 8'h00, 0);
      chk(q, 0);
      apb(1, 8'h10, mp(en) & 'hffff);
      apb(1, 8'h14, mp(en) >> 16);
      go(rr, hit);
      chk(irq, 0);
      apb(0, 8'h18, 0);
      chk(q, {|hit[23:10], |hit[9:0], 3'b111});
      apb(1, 8'h1c, 'h1f);
      // The new mask reaches irq one cycle after the write
      @(posedge pclk);
      chk(irq, 1);
      apb(1, 8'h18, 'h1f);
      chk(irq, 0);
      apb(1, 8'h1c, 0);
    end
    close_out();
  end
  initial begin
    #1500000;
    err_total++;
    close_out();
  end
endmodule
